// *** design/dac_pkg.sv ***
// shared constants, types and helpers for the dual analog comparator control block
package dac_pkg;

  // ==========================================================
  // register map (printed offsets are indices, byte address = 4 * index)
  localparam int APB_AW = 12;                    // apb address width
  localparam logic [7:0] IDX_CMP_ONE = 8'h00ac;  // comparator_one_control
  localparam logic [7:0] IDX_CMP_TWO = 8'h00ad;  // comparator_two_control
  localparam logic [7:0] IDX_INT_STAT = 8'h00b0; // sticky event status, read only
  localparam logic [7:0] IDX_INT_CLR = 8'h00b1;  // write one to clear, write only
  localparam logic [7:0] IDX_INT_EN = 8'h00b2;   // interrupt enable
  localparam logic [7:0] IDX_INT_PRIO = 8'h00b3; // priority and threshold

  // ==========================================================
  // control register fields
  localparam int BIT_EN = 5;   // comparator enable
  localparam int BIT_POS = 4;  // positive input select
  localparam int BIT_NEG = 3;  // negative input select
  localparam int BIT_DRV = 2;  // result to pin
  localparam int BIT_RES = 1;  // synchronised result
  localparam int BIT_FLG = 0;  // change flag
  localparam int BIT_THR = 4;  // threshold bit in the priority register
  localparam int BIT_SETL = 4; // first settled bit in the status register
  localparam logic [31:0] RDATA_RST = 32'h0000_0000; // read data reset value

  // ==========================================================
  // settling time after enable, rounded up to whole cycles
  localparam int CLK_NS = 100;     // pclk period
  localparam int SETTLE_NS = 10000; // 10 us
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] SETTLE_LAST = 7'(SETTLE_CYC - 1);

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01, // waiting for a setup cycle
    ST_ACK = 2'b10   // access phase, pready high
  } dac_apb_st_t;

  typedef struct packed {
    logic en;      // comparator on
    logic pos_sel; // 0 first pin, 1 second pin
    logic neg_sel; // 0 external reference, 1 internal reference
    logic drv;     // route raw result to pin
  } dac_cfg_t;

  typedef struct packed {
    logic en;      // analog core enable
    logic pos_sel; // positive mux select
    logic neg_sel; // negative mux select
  } dac_core_ctl_t;

  typedef struct packed {
    logic s1;        // synchroniser first stage
    logic s2;        // synchroniser second stage
    logic res;       // gated result
    logic chg;       // one-cycle change pulse
    logic settled;   // settling time elapsed
    logic [6:0] cnt; // settling counter
  } dac_chan_st_t;

  typedef struct packed {
    dac_apb_st_t st;     // bus state
    dac_cfg_t cfg_a;     // comparator one config
    dac_cfg_t cfg_b;     // comparator two config
    logic [1:0] flag;    // change flags
    logic [1:0] irq_en;  // interrupt enables
    logic [1:0] prio;    // per-source high priority
    logic thresh;        // only high priority may interrupt
    logic [31:0] rdata;  // read data
    logic ready;         // pready
    logic slverr;        // pslverr
    logic irq;           // interrupt line
    logic [1:0] oe_n;    // pin output enables, low drives
  } dac_top_st_t;

  // byte address of a register index
  function automatic logic [APB_AW-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction

endpackage

// *** design/dac_cmp_chan.sv ***
// one comparator channel: result synchroniser, gating, change and settle detect
`timescale 1ns/1ps
module dac_cmp_chan
  import dac_pkg::*;
(
  input wire logic pclk,     // cpu clock
  input wire logic presetn,  // async reset, low active
  input wire logic en,       // comparator enabled
  input wire logic raw,      // raw analog result, asynchronous
  output logic result,       // synchronised, gated result
  output logic change,       // one-cycle pulse on a result change
  output logic settled       // enable held long enough to trust result
);

  // ==========================================================
  // state
  dac_chan_st_t s_r;   // registered state
  dac_chan_st_t s_nxt; // next state

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    // two flops; only the second stage is looked at
    s_nxt.s1 = raw;                          // see RULE11
    s_nxt.s2 = s_r.s1;                       // see RULE11
    // result reads zero while disabled
    s_nxt.res = s_r.s2 & en;                 // see RULE6
    // both edges count as a change
    s_nxt.chg = (s_r.s2 & en) != s_r.res;    // see RULE7
    // settle counter restarts on every enable
    if (!en) begin
      s_nxt.cnt = '0;
      s_nxt.settled = 1'b0;
    end else if (!s_r.settled) begin
      if (s_r.cnt == SETTLE_LAST) begin
        s_nxt.settled = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 7'h01;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign result = s_r.res;
  assign change = s_r.chg;
  assign settled = s_r.settled;

  // ==========================================================
  // checks
  property p_sync_high;
    @(posedge pclk) disable iff (!presetn) (en && raw)[*4] |-> result;
  endproperty
  a_sync_high: assert property (p_sync_high) else $error("result not high after steady raw"); // see RULE11

  property p_dis_zero;
    @(posedge pclk) disable iff (!presetn) !en |=> !result;
  endproperty
  a_dis_zero: assert property (p_dis_zero) else $error("result not zero while disabled"); // see RULE6

  property p_chg_edge;
    @(posedge pclk) disable iff (!presetn) ##1 (change == (result != $past(result)));
  endproperty
  a_chg_edge: assert property (p_chg_edge) else $error("change pulse not tied to result edge"); // see RULE7

endmodule

// *** design/dac_ctrl.sv ***
// top of the dual analog comparator control block with its apb register file
// ==========================================================
// Behaviour
// RULE1 - control bit 5 switches comparator on
// RULE2 - software waits 10 us after first enable
// RULE3 - bit 4 picks first or second positive pin
// RULE4 - bit 3 picks external or internal reference
// RULE5 - bit 2 drives raw result onto pin
// RULE6 - bit 1 shows synced result, zero when off
// RULE7 - bit 0 set on any result change
// RULE8 - flag interrupts when enabled and priority allows
// RULE9 - flag stays until written zero or disabled
// RULE10 - second comparator identical with own register
// RULE11 - raw result passes two-flop synchroniser
// RULE12 - bits 7:6 read zero, controls reset zero
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module dac_ctrl
  import dac_pkg::*;
(
  input wire logic pclk,                 // cpu clock, 10 MHz
  input wire logic presetn,              // async reset, low active
  input wire logic [APB_AW-1:0] paddr,   // apb byte address
  input wire logic psel,                 // apb select
  input wire logic penable,              // apb access phase
  input wire logic pwrite,               // apb direction, high writes
  input wire logic [31:0] pwdata,        // apb write data
  input wire logic [3:0] pstrb,          // apb byte strobes
  output logic [31:0] prdata,            // apb read data
  output logic pready,                   // apb ready
  output logic pslverr,                  // apb error on unmapped address
  input wire logic cmp_a_raw,            // comparator one raw result
  input wire logic cmp_b_raw,            // comparator two raw result
  output dac_core_ctl_t cmp_a_core,      // comparator one analog controls
  output dac_core_ctl_t cmp_b_core,      // comparator two analog controls
  output logic cmp_a_pin_o,              // comparator one output pin value
  output logic cmp_a_pin_oe_n,           // comparator one pin enable, low drives
  output logic cmp_b_pin_o,              // comparator two output pin value
  output logic cmp_b_pin_oe_n,           // comparator two pin enable, low drives
  output logic irq                       // level interrupt request
);

  // ==========================================================
  // address decode
  localparam logic [APB_AW-1:0] ADDR_ONE = reg_addr(IDX_CMP_ONE);   // control one
  localparam logic [APB_AW-1:0] ADDR_TWO = reg_addr(IDX_CMP_TWO);   // control two
  localparam logic [APB_AW-1:0] ADDR_STAT = reg_addr(IDX_INT_STAT); // status
  localparam logic [APB_AW-1:0] ADDR_CLR = reg_addr(IDX_INT_CLR);   // clear
  localparam logic [APB_AW-1:0] ADDR_EN = reg_addr(IDX_INT_EN);     // enable
  localparam logic [APB_AW-1:0] ADDR_PRIO = reg_addr(IDX_INT_PRIO); // priority

  // ==========================================================
  // helpers

  // control register read image; upper bits always zero
  function automatic logic [31:0] ctl_image(
    input dac_cfg_t cfg,
    input logic res,
    input logic flg
  );
    logic [31:0] v;
    v = '0;                  // bits 7:6 and above read zero, see RULE12
    v[BIT_EN] = cfg.en;
    v[BIT_POS] = cfg.pos_sel;
    v[BIT_NEG] = cfg.neg_sel;
    v[BIT_DRV] = cfg.drv;
    v[BIT_RES] = res;
    v[BIT_FLG] = flg;
    ctl_image = v;
  endfunction

  // control register write; only the four control bits store
  function automatic dac_cfg_t ctl_write(input logic [31:0] d);
    dac_cfg_t c;
    c.en = d[BIT_EN];        // see RULE1
    c.pos_sel = d[BIT_POS];  // see RULE3
    c.neg_sel = d[BIT_NEG];  // see RULE4
    c.drv = d[BIT_DRV];
    ctl_write = c;
  endfunction

  // ==========================================================
  // state
  dac_top_st_t s_r;    // registered state
  dac_top_st_t s_nxt;  // next state
  logic res_a;         // synced result one
  logic res_b;         // synced result two
  logic chg_a;         // change pulse one
  logic chg_b;         // change pulse two
  logic setl_a;        // settled one
  logic setl_b;        // settled two
  logic hit_one;       // address decode hits
  logic hit_two;
  logic hit_stat;
  logic hit_clr;
  logic hit_en;
  logic hit_prio;
  logic mapped;        // any register hit
  logic wr_go;         // write takes effect this edge
  logic [31:0] rd_mux; // read data selection
  logic [1:0] clr;     // software clear per flag
  logic [1:0] set;     // hardware set per flag
  logic [1:0] elig;    // sources passing the priority threshold

  // ==========================================================
  // channels; the second is the same logic with its own inputs
  dac_cmp_chan u_chan_a (
    .pclk(pclk),
    .presetn(presetn),
    .en(s_r.cfg_a.en),
    .raw(cmp_a_raw),
    .result(res_a),
    .change(chg_a),
    .settled(setl_a)
  );

  // see RULE10
  dac_cmp_chan u_chan_b (
    .pclk(pclk),
    .presetn(presetn),
    .en(s_r.cfg_b.en),
    .raw(cmp_b_raw),
    .result(res_b),
    .change(chg_b),
    .settled(setl_b)
  );

  // ==========================================================
  // decode and read mux
  always_comb begin
    hit_one = paddr == ADDR_ONE;
    hit_two = paddr == ADDR_TWO;
    hit_stat = paddr == ADDR_STAT;
    hit_clr = paddr == ADDR_CLR;
    hit_en = paddr == ADDR_EN;
    hit_prio = paddr == ADDR_PRIO;
    mapped = hit_one | hit_two | hit_stat | hit_clr | hit_en | hit_prio;
    // a write lands only at the edge that completes the access phase
    wr_go = psel & penable & s_r.ready & pwrite & pstrb[0] & mapped;
    rd_mux = '0;
    if (hit_one) begin
      rd_mux = ctl_image(s_r.cfg_a, res_a, s_r.flag[0]);  // see RULE6
    end else if (hit_two) begin
      rd_mux = ctl_image(s_r.cfg_b, res_b, s_r.flag[1]);  // see RULE10
    end else if (hit_stat) begin
      rd_mux[1:0] = s_r.flag;
      rd_mux[BIT_SETL] = setl_a;
      rd_mux[BIT_SETL+1] = setl_b;
    end else if (hit_en) begin
      rd_mux[1:0] = s_r.irq_en;
    end else if (hit_prio) begin
      rd_mux[1:0] = s_r.prio;
      rd_mux[BIT_THR] = s_r.thresh;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;

    // apb handshake: one access cycle, no wait states
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.ready = 1'b0;
        s_nxt.slverr = 1'b0;
        if (psel && !penable) begin
          s_nxt.st = ST_ACK;
          s_nxt.ready = 1'b1;
          s_nxt.slverr = !mapped;
          // read data is captured at the setup edge
          s_nxt.rdata = pwrite ? RDATA_RST : rd_mux;
        end
      end
      ST_ACK: begin
        // access phase always follows setup, so the transfer ends here
        if (psel && penable) begin
          s_nxt.st = ST_IDLE;
          s_nxt.ready = 1'b0;
          s_nxt.slverr = 1'b0;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
        s_nxt.ready = 1'b0;
        s_nxt.slverr = 1'b0;
      end
    endcase

    // register writes; read-only bits and bits 7:6 ignore data
    clr = 2'b00;
    if (wr_go && hit_one) begin
      s_nxt.cfg_a = ctl_write(pwdata);         // see RULE1
      clr[0] = !pwdata[BIT_FLG];               // writing zero clears, see RULE9
    end
    if (wr_go && hit_two) begin
      s_nxt.cfg_b = ctl_write(pwdata);         // see RULE10
      clr[1] = !pwdata[BIT_FLG];
    end
    if (wr_go && hit_clr) begin
      clr = clr | pwdata[1:0];
    end
    if (wr_go && hit_en) begin
      s_nxt.irq_en = pwdata[1:0];
    end
    if (wr_go && hit_prio) begin
      s_nxt.prio = pwdata[1:0];
      s_nxt.thresh = pwdata[BIT_THR];
    end

    // change flags: a set in the same cycle as a clear wins;
    // a disabled comparator holds its flag at zero
    set = {chg_b, chg_a};                      // see RULE7
    s_nxt.flag[0] = s_r.cfg_a.en & (set[0] | (s_r.flag[0] & !clr[0])); // see RULE9
    s_nxt.flag[1] = s_r.cfg_b.en & (set[1] | (s_r.flag[1] & !clr[1])); // see RULE9

    // with the threshold set only high-priority sources interrupt
    elig = s_nxt.prio | {2{!s_nxt.thresh}};
    s_nxt.irq = |(s_nxt.flag & s_nxt.irq_en & elig);  // see RULE8

    // pin enables follow enable and drive bits
    s_nxt.oe_n[0] = !(s_nxt.cfg_a.en & s_nxt.cfg_a.drv); // see RULE5
    s_nxt.oe_n[1] = !(s_nxt.cfg_b.en & s_nxt.cfg_b.drv);
  end

  // ==========================================================
  // state register; every control field resets to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;                               // see RULE12
      s_r.st <= ST_IDLE;
      s_r.oe_n <= 2'b11;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.slverr;
  assign irq = s_r.irq;
  assign cmp_a_core = '{en: s_r.cfg_a.en, pos_sel: s_r.cfg_a.pos_sel, neg_sel: s_r.cfg_a.neg_sel}; // see RULE3
  assign cmp_b_core = '{en: s_r.cfg_b.en, pos_sel: s_r.cfg_b.pos_sel, neg_sel: s_r.cfg_b.neg_sel}; // see RULE4
  // the pin path is deliberately unclocked, so glitches on raw reach the pin
  assign cmp_a_pin_o = cmp_a_raw & s_r.cfg_a.en & s_r.cfg_a.drv;  // see RULE5
  assign cmp_b_pin_o = cmp_b_raw & s_r.cfg_b.en & s_r.cfg_b.drv;  // see RULE5
  assign cmp_a_pin_oe_n = s_r.oe_n[0];
  assign cmp_b_pin_oe_n = s_r.oe_n[1];

  // ==========================================================
  // checks
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_wr_one;
    psel && penable && pready && pwrite && pstrb[0] && (paddr == ADDR_ONE);
  endsequence

  property p_apb_ack;
    @(posedge pclk) disable iff (!presetn) s_setup |=> pready ##1 !pready;
  endproperty
  a_apb_ack: assert property (p_apb_ack) else $error("pready not a single access cycle");

  property p_en_write;
    @(posedge pclk) disable iff (!presetn) s_wr_one |=> (cmp_a_core.en == $past(pwdata[BIT_EN]));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable bit not stored"); // see RULE1

  property p_pos_write;
    @(posedge pclk) disable iff (!presetn) s_wr_one |=> (cmp_a_core.pos_sel == $past(pwdata[BIT_POS]));
  endproperty
  a_pos_write: assert property (p_pos_write) else $error("positive select not stored"); // see RULE3

  property p_neg_write;
    @(posedge pclk) disable iff (!presetn) s_wr_one |=> (cmp_a_core.neg_sel == $past(pwdata[BIT_NEG]));
  endproperty
  a_neg_write: assert property (p_neg_write) else $error("negative select not stored"); // see RULE4

  property p_pin;
    @(posedge pclk) disable iff (!presetn) cmp_a_pin_o == (cmp_a_raw && !cmp_a_pin_oe_n);
  endproperty
  a_pin: assert property (p_pin) else $error("pin value not raw result"); // see RULE5

  property p_rd_res;
    @(posedge pclk) disable iff (!presetn)
      s_setup and (paddr == ADDR_ONE) and !pwrite |=> prdata[BIT_RES] == $past(res_a);
  endproperty
  a_rd_res: assert property (p_rd_res) else $error("read result bit mismatch"); // see RULE6

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn) (chg_a && cmp_a_core.en) |=> s_r.flag[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("change did not set flag"); // see RULE7

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      irq == |(s_r.flag & s_r.irq_en & (s_r.prio | {2{!s_r.thresh}}));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt line disagrees with flags"); // see RULE8

  property p_flag_off;
    @(posedge pclk) disable iff (!presetn) !cmp_b_core.en |=> !s_r.flag[1];
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("flag held while disabled"); // see RULE9

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
      s_r.flag[0] && cmp_a_core.en && !wr_go |=> s_r.flag[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear"); // see RULE9

  property p_rsvd;
    @(posedge pclk) disable iff (!presetn) pready && (paddr == ADDR_TWO) |-> prdata[7:6] == 2'b00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero"); // see RULE12

  // comparator two stores like comparator one
  sequence s_wr_two;
    psel && penable && pready && pwrite && pstrb[0] && (paddr == ADDR_TWO);
  endsequence

  property p_b_write;
    @(posedge pclk) disable iff (!presetn) s_wr_two |=> cmp_b_core == $past(pwdata[BIT_EN:BIT_NEG]);
  endproperty
  a_b_write: assert property (p_b_write) else $error("comparator two controls not stored"); // see RULE10

  // a zero write clears the flag unless a change lands
  property p_flag_clr;
    @(posedge pclk) disable iff (!presetn) s_wr_one and !pwdata[BIT_FLG] and !chg_a |=> !s_r.flag[0];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared by zero write"); // see RULE9

  // pin enable moves with the written bits
  property p_oe_write;
    @(posedge pclk) disable iff (!presetn)
      s_wr_one |=> cmp_a_pin_oe_n == !($past(pwdata[BIT_EN]) && $past(pwdata[BIT_DRV]));
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("pin enable not set by write"); // see RULE5

  // unmapped addresses answer with an error
  property p_slverr;
    @(posedge pclk) disable iff (!presetn) s_setup |=> pslverr == !$past(mapped);
  endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr wrong for address");

endmodule

// *** dv/dac_core_model.sv ***
// behavioural model of one analog comparator core feeding the control block
`timescale 1ns/1ps
module dac_core_model
  import dac_pkg::*;
#(
  parameter logic [3:0] INT_REF = 4'h8 // internal reference level, plain default
)(
  input wire logic pclk,              // cpu clock, paces the unsettled pattern
  input wire logic presetn,           // async reset, low active
  input wire dac_core_ctl_t ctl,      // enable and input selects
  input wire logic [3:0] pos_first,   // first positive pin level
  input wire logic [3:0] pos_second,  // second positive pin level
  input wire logic [3:0] ext_ref,     // external reference pin level
  output logic raw                    // raw comparison result
);
  logic [6:0] age_r;  // cycles since enable
  logic wobble_r;     // meaningless output while off or settling
  logic [3:0] pos_lvl; // chosen positive level
  logic [3:0] neg_lvl; // chosen negative level

  // ==========================================================
  // settle counter: a fresh core is not trusted, so it wobbles meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_r <= 7'h00;
      wobble_r <= 1'b0;
    end else begin
      wobble_r <= ~wobble_r;
      if (!ctl.en) begin
        age_r <= 7'h00; // restart on every disable
      end else if (age_r != SETTLE_LAST) begin
        age_r <= age_r + 7'h01;
      end
    end
  end

  // ==========================================================
  // input muxes and comparison
  assign pos_lvl = ctl.pos_sel ? pos_second : pos_first;
  assign neg_lvl = ctl.neg_sel ? INT_REF : ext_ref;
  // an off or unsettled core changes every cycle, never a steady guess
  assign raw = (ctl.en && age_r == SETTLE_LAST) ? (pos_lvl > neg_lvl) : wobble_r;
endmodule

// *** dv/dual_analog_comparator_ctrl_bench.sv ***
// self-checking bench for the dual analog comparator control block
`timescale 1ns/1ps
module dual_analog_comparator_ctrl_bench;
  import dac_pkg::*;
  typedef struct packed {
    logic [31:0] exp;  // expected read data
    logic [31:0] mask; // bits that matter
    logic err;         // expected pslverr
  } dac_note_t;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, seed, exp;
  logic [3:0] pstrb;
  logic cmp_a_raw, cmp_b_raw, cmp_a_pin_o, cmp_b_pin_o, cmp_a_pin_oe_n, cmp_b_pin_oe_n;
  dac_core_ctl_t cmp_a_core, cmp_b_core;
  logic [3:0] lvl [5]; // a first, a second, b first, b second, external ref
  logic [7:0] idx;
  logic r;
  dac_note_t notes[$];
  dac_note_t note;
  int errors, checks;

  dac_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_a_raw(cmp_a_raw), .cmp_b_raw(cmp_b_raw), .cmp_a_core(cmp_a_core), .cmp_b_core(cmp_b_core),
    .cmp_a_pin_o(cmp_a_pin_o), .cmp_a_pin_oe_n(cmp_a_pin_oe_n), .cmp_b_pin_o(cmp_b_pin_o),
    .cmp_b_pin_oe_n(cmp_b_pin_oe_n), .irq(irq));
  dac_core_model m_a (.pclk(pclk), .presetn(presetn), .ctl(cmp_a_core), .pos_first(lvl[0]),
    .pos_second(lvl[1]), .ext_ref(lvl[4]), .raw(cmp_a_raw));
  dac_core_model m_b (.pclk(pclk), .presetn(presetn), .ctl(cmp_b_core), .pos_first(lvl[2]),
    .pos_second(lvl[3]), .ext_ref(lvl[4]), .raw(cmp_b_raw));

  // ==========================================================
  // clock, random source and reporting
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task final_report;
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] e, input logic [31:0] got);
    checks++;
    if (got !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask

  // ==========================================================
  // apb master: setup, access, hold until pready seen at an edge
  task apb(input logic w, input logic [7:0] i, input logic [31:0] d, input logic [31:0] e,
           input logic [31:0] m, input logic er);
    int n;
    notes.push_back(dac_note_t'{e, m, er});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= reg_addr(i);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, i, d, 32'h0000_0000, 32'h0000_0000, 1'b0);
  endtask

  task rd(input logic [7:0] i, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, i, 32'h0000_0000, e, m, 1'b0);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ==========================================================
  // monitor: each finished transfer is compared with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        chk("unexpected transfer", 32'h0000_0000, 32'h0000_0001);
      end else begin
        note = notes.pop_front();
        chk("pslverr", {31'h0, note.err}, {31'h0, pslverr});
        if (!pwrite) chk("prdata", note.exp & note.mask, prdata & note.mask);
      end
    end
  end

  // watchdog against a hung run
  initial begin
    cyc(50000);
    errors++;
    final_report();
  end

  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    seed = 32'h0000_40b6;
    errors = 0;
    checks = 0;
    foreach (lvl[i]) lvl[i] = 4'h0;
    cyc(5);
    presetn <= 1'b1;
    // reset state
    rd(IDX_CMP_ONE, 32'h0000_0000, 32'hffff_ffff);
    rd(IDX_CMP_TWO, 32'h0000_0000, 32'hffff_ffff);
    chk("oe_n", 32'h0000_0003, {30'h0, cmp_b_pin_oe_n, cmp_a_pin_oe_n});
    chk("irq", 32'h0000_0000, {31'h0, irq});
    // refused accesses, then a read of the write-only clear register
    apb(1'b0, 8'h00, 32'h0000_0000, 32'h0000_0000, 32'hffff_ffff, 1'b1);
    apb(1'b1, 8'hae, 32'h0000_00ff, 32'h0000_0000, 32'h0000_0000, 1'b1);
    rd(IDX_INT_CLR, 32'h0000_0000, 32'hffff_ffff);
    wr(IDX_INT_EN, 32'h0000_0003);
    for (int ch = 0; ch < 2; ch++) begin
      idx = 8'(IDX_CMP_ONE + ch);
      seed = lfsr(seed);
      wr(idx, {seed[31:8], 8'hfc});
      rd(idx, 32'h0000_003c, 32'hffff_fffc);
      exp = {29'h0, (ch == 0) ? cmp_a_core : cmp_b_core};
      chk("core", 32'h0000_0007, exp);
      exp = {31'h0, (ch == 0) ? cmp_a_pin_oe_n : cmp_b_pin_oe_n};
      chk("oe_n", 32'h0000_0000, exp);
      cyc(110);
      // every input selection with random pin levels
      for (int sel = 0; sel < 4; sel++) begin
        seed = lfsr(seed);
        lvl[2 * ch] <= seed[3:0];
        lvl[2 * ch + 1] <= seed[7:4];
        lvl[4] <= seed[11:8];
        wr(idx, {26'h0, 1'b1, 2'(sel), 3'b100});
        cyc(6);
        r = ((sel / 2) ? lvl[2 * ch + 1] : lvl[2 * ch]) > ((sel % 2) ? 4'h8 : lvl[4]);
        rd(idx, {26'h0, 1'b1, 2'(sel), 1'b1, r, 1'b0}, 32'hffff_fffe);
        chk("pin", {31'h0, r}, {31'h0, ch ? cmp_b_pin_o : cmp_a_pin_o});
      end
      // falling change sets the flag and requests an interrupt
      lvl[2 * ch] <= 4'hc;
      lvl[4] <= 4'h4;
      wr(idx, 32'h0000_0024);
      cyc(8);
      wr(idx, 32'h0000_0024);
      cyc(3);
      rd(idx, 32'h0000_0026, 32'hffff_ffff);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      lvl[2 * ch] <= 4'h1;
      cyc(8);
      rd(idx, 32'h0000_0025, 32'hffff_ffff);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      wr(idx, 32'h0000_0025);
      rd(idx, 32'h0000_0025, 32'hffff_ffff);
      exp = 32'h0000_0011 << ch;
      rd(IDX_INT_STAT, exp, exp);
      // threshold, priority and enable gate the request
      wr(IDX_INT_PRIO, 32'h0000_0010);
      cyc(3);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      wr(IDX_INT_PRIO, 32'h0000_0010 | (32'h1 << ch));
      cyc(3);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      wr(IDX_INT_PRIO, 32'h0000_0000);
      wr(IDX_INT_EN, 32'h0000_0000);
      cyc(3);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      wr(IDX_INT_EN, 32'h0000_0003);
      // a write without the low strobe leaves the flag alone
      pstrb <= 4'he;
      wr(idx, 32'h0000_0000);
      pstrb <= 4'hf;
      cyc(3);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      wr(IDX_INT_CLR, 32'h1 << ch);
      cyc(3);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      // rising change, then disable clears result and flag
      lvl[2 * ch] <= 4'hc;
      cyc(8);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      wr(idx, 32'h0000_0004);
      cyc(4);
      rd(idx, 32'h0000_0004, 32'hffff_ffff);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      exp = {30'h0, ch ? {cmp_b_pin_oe_n, cmp_b_pin_o} : {cmp_a_pin_oe_n, cmp_a_pin_o}};
      chk("pin off", 32'h0000_0002, exp);
    end
    cyc(3);
    final_report();
  end
endmodule
